/* File: hw/hdsrx_pkg.sv */
// shared constants for the hd serial receiver lock and deserializer block
package hdsrx_pkg;
	localparam int WORD_W = 20;
	localparam int HALF_WORD = 10;
	localparam logic [4:0] CNT_LAST = 5'h13;
	localparam logic [4:0] CNT_HALF = 5'h0a;
	// phase lock filter, normalised fraction in 16 bits
	localparam int PL_W = 16;
	localparam int PL_SHIFT = 6;
	localparam logic [15:0] PL_STEP = 16'h03ff;
	localparam logic [15:0] PL_THRESH = 16'ha8f6;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h0c;
	localparam logic [7:0] OFS_IRQ_EN = 8'h10;
	localparam logic [7:0] OFS_WORD = 8'h14;
	localparam logic [1:0] CTRL_RESET = 2'h1;
	localparam int CTRL_SWEEP_EN = 0;
	localparam int CTRL_MUTE_EN = 1;
	// status bit positions
	localparam int ST_LOCK = 0;
	localparam int ST_PHASE = 1;
	localparam int ST_DATA = 2;
	localparam int ST_SW_UP = 3;
	localparam int ST_SW_DN = 4;
	localparam int ST_MUTE = 5;
	localparam int ST_CARRIER = 6;
	localparam int ST_BYPASS = 7;
	// interrupt event positions
	localparam int IRQ_N = 4;
	localparam int EV_LOCK_UP = 0;
	localparam int EV_LOCK_DN = 1;
	localparam int EV_REVERSE = 2;
	localparam int EV_CARRIER = 3;
	// pin synchroniser positions
	localparam int PIN_N = 11;
	localparam int P_ANA = 0;
	localparam int P_DIG = 1;
	localparam int P_SAT_HI = 2;
	localparam int P_SAT_LO = 3;
	localparam int P_QUAD = 4;
	localparam int P_BYP_N = 5;
	localparam int P_DRV_N = 6;
	localparam int P_ASEL = 7;
	localparam int P_CARR = 8;
	localparam int P_LVL_LO = 9;
	localparam int P_ADJ = 10;
	typedef enum logic [1:0] {SW_UP, SW_DOWN, SW_HOLD} hdsrx_sweep_e;
endpackage

/* File: hw/hdsrx_word_if.sv */
// link between the receive front end and the deserializer
`timescale 1ns/100ps
interface hdsrx_word_if;
	import hdsrx_pkg::*;
	logic              serial_bit;
	logic              mute;
	logic [WORD_W-1:0] word;
	logic              pclk;
	logic              word_stb;
	modport src (output serial_bit, output mute, input word, input pclk, input word_stb);
	modport deser (input serial_bit, input mute, output word, output pclk, output word_stb);
endinterface

/* File: hw/hdsrx_phase_lock.sv */
// phase lock detector: filtered in-window transition fraction
`timescale 1ns/100ps
module hdsrx_phase_lock import hdsrx_pkg::*; (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// transition events
	input  wire logic trans_i,
	input  wire logic in_window_i,
	// result
	output logic      phase_lock_o
);
	logic [PL_W-1:0] acc_reg;
	logic [PL_W-1:0] acc_next;

	always_comb begin
		acc_next = acc_reg - (acc_reg >> PL_SHIFT) + (in_window_i ? PL_STEP : 16'h0000);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_reg <= 16'h0000;
		end else if (trans_i) begin
			acc_reg <= acc_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_lock_o <= 1'b0;
		end else begin
			phase_lock_o <= acc_reg > PL_THRESH;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_lock_threshold: assert property ((acc_reg > PL_THRESH) |=> phase_lock_o) else $error("phase lock missed");
	a_acc_hold: assert property (!trans_i |=> $stable(acc_reg)) else $error("filter moved");
	c_phase_lock: cover property ($rose(phase_lock_o));
endmodule

/* File: hw/hdsrx_deser.sv */
// 1:20 serial to parallel converter with free running word clock
`timescale 1ns/100ps
module hdsrx_deser import hdsrx_pkg::*; (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// word link
	hdsrx_word_if.deser lnk
);
	logic [4:0]        cnt_reg;
	logic [WORD_W-1:0] shift_reg;

	// divide by twenty, never gated by lock
	always_ff @(posedge clk_i) begin
		if (rst_i || cnt_reg == CNT_LAST) begin
			cnt_reg <= 5'h00;
		end else begin
			cnt_reg <= cnt_reg + 5'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lnk.pclk <= 1'b0;
		end else begin
			lnk.pclk <= cnt_reg < (CNT_HALF - 5'h01) || cnt_reg == CNT_LAST;
		end
	end

	// first bit lands in bit 0
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shift_reg <= '0;
		end else begin
			shift_reg <= {lnk.serial_bit, shift_reg[WORD_W-1:1]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lnk.word <= '0;
			lnk.word_stb <= 1'b0;
		end else begin
			lnk.word_stb <= cnt_reg == CNT_LAST;
			if (cnt_reg == CNT_LAST) begin
				lnk.word <= lnk.mute ? '0 : {lnk.serial_bit, shift_reg[WORD_W-1:1]};
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_word_period: assert property (lnk.word_stb |=> !lnk.word_stb [*8] ##12 lnk.word_stb) else $error("word period not 20");
	a_pclk_rise: assert property (lnk.word_stb |-> lnk.pclk ##10 !lnk.pclk) else $error("pclk shape wrong");
	a_word_bits: assert property ((cnt_reg == CNT_LAST && !lnk.mute) |=> lnk.word[0] == $past(shift_reg[1])) else $error("bit order wrong");
	c_word: cover property (lnk.word_stb && lnk.word != '0);
endmodule

/* File: hw/hdsrx_top.sv */
// hd serial receiver lock logic, input routing, mute and word output
//
// Summary of operation
// - lock drops without data or phase lock
// - integrator saturation means no data present
// - sweep integrator by injecting summing current
// - sweep stops once phase lock asserts
// - sweep direction reverses at either saturation
// - bypass low routes around reclock path
// - bypass mode: mute never touches words
// - bypass keeps loop locking and lock report
// - drive enable low enables serial driver
// - select high picks analog, low digital
// - carrier_present_n low while carrier seen
// - mute below level; unconnected adjust disables
// - serial stream becomes 20-bit words
// - no word alignment nor descrambling
// - word clock is serial rate over twenty
// - word clock freewheels when lock lost
// - phase lock above 0.66 window fraction
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
module hdsrx_top import hdsrx_pkg::*; (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// serial and analog front end pins
	input  wire logic              analog_bit_i,
	input  wire logic              digital_bit_i,
	input  wire logic              integrator_sat_high_i,
	input  wire logic              integrator_sat_low_i,
	input  wire logic              quad_window_i,
	input  wire logic              carrier_detect_i,
	input  wire logic              level_low_i,
	input  wire logic              mute_level_adjust_i,
	// mode pins
	input  wire logic              bypass_n_i,
	input  wire logic              serial_drive_enable_n_i,
	input  wire logic              analog_select_i,
	// loop control
	output logic                   sweep_up_o,
	output logic                   sweep_down_o,
	output logic                   lock_o,
	// serial output driver
	output logic                   serial_drive_out_o,
	output logic                   serial_drive_oe_o,
	// status pins
	output logic                   carrier_present_n_o,
	output logic                   mute_o,
	// parallel output
	output logic      [WORD_W-1:0] par_data_o,
	output logic                   pclk_o,
	// interrupt
	output logic                   irq_o
);
	logic [PIN_N-1:0] pin_raw;
	logic [PIN_N-1:0] pin_meta_reg;
	logic [PIN_N-1:0] pin_reg;
	logic             sel_bit;
	logic             reclk_reg;
	logic             prev_reg;
	logic             trans;
	logic             phase_lock;
	logic             data_present;
	logic             bypass_act;
	hdsrx_sweep_e     sweep_reg;
	hdsrx_sweep_e     sweep_next;
	logic [1:0]       ctrl_reg;
	logic [IRQ_N-1:0] irq_stat_reg;
	logic [IRQ_N-1:0] irq_en_reg;
	logic [IRQ_N-1:0] events;
	logic             carr_prev_reg;
	logic             wb_req;
	logic             wb_wr;
	logic [7:0]       status;

	hdsrx_word_if lnk ();

	// pins gathered in synchroniser order
	assign pin_raw = {mute_level_adjust_i, level_low_i, carrier_detect_i, analog_select_i,
		serial_drive_enable_n_i, bypass_n_i, quad_window_i, integrator_sat_low_i,
		integrator_sat_high_i, digital_bit_i, analog_bit_i};

	// two flip-flop synchronisers for every pin
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pin_meta_reg[gi] <= 1'b0;
					pin_reg[gi] <= 1'b0;
				end else begin
					pin_meta_reg[gi] <= pin_raw[gi];
					pin_reg[gi] <= pin_meta_reg[gi];
				end
			end
		end
	endgenerate

	assign sel_bit = pin_reg[P_ASEL] ? pin_reg[P_ANA] : pin_reg[P_DIG];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reclk_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			reclk_reg <= sel_bit;
			prev_reg <= sel_bit;
		end
	end

	assign trans = sel_bit != prev_reg;

	hdsrx_phase_lock u_phase_lock (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.trans_i      (trans),
		.in_window_i  (pin_reg[P_QUAD]),
		.phase_lock_o (phase_lock)
	);

	assign data_present = !(pin_reg[P_SAT_HI] || pin_reg[P_SAT_LO]);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_o <= 1'b0;
		end else begin
			lock_o <= data_present && phase_lock;
		end
	end

	always_comb begin
		sweep_next = sweep_reg;
		case (sweep_reg)
			SW_UP: begin
				if (pin_reg[P_SAT_HI]) begin
					sweep_next = SW_DOWN;
				end
			end
			SW_DOWN: begin
				if (pin_reg[P_SAT_LO]) begin
					sweep_next = SW_UP;
				end
			end
			SW_HOLD: begin
				sweep_next = SW_UP;
			end
			default: begin
				sweep_next = SW_HOLD;
			end
		endcase
		if (phase_lock || !ctrl_reg[CTRL_SWEEP_EN]) begin
			sweep_next = SW_HOLD;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sweep_reg <= SW_HOLD;
		end else begin
			sweep_reg <= sweep_next;
		end
	end

	assign sweep_up_o = sweep_reg == SW_UP;
	assign sweep_down_o = sweep_reg == SW_DOWN;

	// bypass low skips the reclock flop
	assign bypass_act = !pin_reg[P_BYP_N];
	assign lnk.serial_bit = bypass_act ? sel_bit : reclk_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_drive_out_o <= 1'b0;
			serial_drive_oe_o <= 1'b0;
			mute_o <= 1'b0;
			carrier_present_n_o <= 1'b1;
		end else begin
			serial_drive_out_o <= lnk.serial_bit;
			serial_drive_oe_o <= !pin_reg[P_DRV_N];
			mute_o <= pin_reg[P_LVL_LO] && pin_reg[P_ADJ] && ctrl_reg[CTRL_MUTE_EN] && !bypass_act;
			carrier_present_n_o <= !pin_reg[P_CARR];
		end
	end

	assign lnk.mute = mute_o;

	hdsrx_deser u_deser (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.lnk   (lnk.deser)
	);

	assign par_data_o = lnk.word;
	assign pclk_o = lnk.pclk;

	// wishbone slave, one wait state; writes land on the ack edge
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= CTRL_RESET;
			irq_en_reg <= '0;
		end else if (wb_wr) begin
			if (wb_adr_i == OFS_CTRL) begin
				ctrl_reg <= wb_dat_i[1:0];
			end
			if (wb_adr_i == OFS_IRQ_EN) begin
				irq_en_reg <= wb_dat_i[IRQ_N-1:0];
			end
		end
	end

	assign status = {bypass_act, !carrier_present_n_o, mute_o, sweep_down_o, sweep_up_o,
		data_present, phase_lock, lock_o};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_req && !wb_we_i) begin
			case (wb_adr_i)
				OFS_CTRL: wb_dat_o <= {30'h0000_0000, ctrl_reg};
				OFS_STATUS: wb_dat_o <= {24'h00_0000, status};
				OFS_IRQ_STAT: wb_dat_o <= {28'h000_0000, irq_stat_reg};
				OFS_IRQ_EN: wb_dat_o <= {28'h000_0000, irq_en_reg};
				OFS_WORD: wb_dat_o <= {12'h000, lnk.word};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// interrupt events
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			carr_prev_reg <= 1'b0;
		end else begin
			carr_prev_reg <= pin_reg[P_CARR];
		end
	end

	assign events[EV_LOCK_UP] = data_present && phase_lock && !lock_o;
	assign events[EV_LOCK_DN] = !(data_present && phase_lock) && lock_o;
	assign events[EV_REVERSE] = sweep_reg != SW_HOLD && sweep_next != SW_HOLD && sweep_next != sweep_reg;
	assign events[EV_CARRIER] = pin_reg[P_CARR] != carr_prev_reg;

	// set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_reg <= '0;
		end else if (wb_wr && wb_adr_i == OFS_IRQ_CLR) begin
			irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[IRQ_N-1:0]) | events;
		end else begin
			irq_stat_reg <= irq_stat_reg | events;
		end
	end

	assign irq_o = |(irq_stat_reg & irq_en_reg);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_lock_needs_data: assert property (lock_o |-> $past(data_present && phase_lock)) else $error("lock without cause");
	a_sat_drops_lock: assert property ((pin_reg[P_SAT_HI] || pin_reg[P_SAT_LO]) |=> !lock_o) else $error("lock in saturation");
	a_sweep_enabled: assert property ((ctrl_reg[CTRL_SWEEP_EN] && !phase_lock && sweep_reg == SW_HOLD) |=> (sweep_up_o || sweep_down_o)) else $error("sweep not started");
	a_sweep_stop: assert property (phase_lock |=> !sweep_up_o && !sweep_down_o) else $error("sweep while phase locked");
	a_sweep_reverse: assert property ((sweep_up_o && pin_reg[P_SAT_HI] && !phase_lock && ctrl_reg[CTRL_SWEEP_EN]) |=> sweep_down_o) else $error("sweep not reversed");
	a_bypass_route: assert property (bypass_act |-> lnk.serial_bit == sel_bit) else $error("bypass not routed");
	a_bypass_no_mute: assert property (bypass_act |=> !mute_o) else $error("mute in bypass");
	a_drive_enable: assert property (pin_reg[P_DRV_N] |=> !serial_drive_oe_o) else $error("driver not disabled");
	a_carrier_out: assert property (pin_reg[P_CARR] |=> !carrier_present_n_o) else $error("carrier not shown");
	a_mute_level: assert property ((pin_reg[P_LVL_LO] && pin_reg[P_ADJ] && ctrl_reg[CTRL_MUTE_EN] && !bypass_act) |=> mute_o) else $error("mute missed");
	a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_irq_sticky: assert property ((events != '0) |=> (irq_stat_reg & $past(events)) == $past(events)) else $error("event not latched");
	c_lock_gained: cover property ($rose(lock_o));
	c_sweep_reverse: cover property (sweep_up_o ##1 sweep_down_o);
	c_bypass_lock: cover property (bypass_act && lock_o);
endmodule

/* File: sim/hdsrx_deform_model.sv */
// downstream word sink model: takes raw words on the word clock
`timescale 1ns/100ps
module hdsrx_deform_model import hdsrx_pkg::*; (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// parallel link
	input  wire logic [WORD_W-1:0] par_data_i,
	input  wire logic              pclk_i,
	// capture results
	output logic      [WORD_W-1:0] word_o,
	output logic      [7:0]        period_o,
	output logic      [7:0]        high_o
);
	logic       pclk_reg;
	logic [7:0] cnt_reg;
	logic [7:0] hi_reg;
	always_ff @(posedge clk_i) begin
		pclk_reg <= pclk_i;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 8'h00;
			hi_reg <= 8'h00;
			period_o <= 8'h00;
			high_o <= 8'h00;
			word_o <= '0;
		end else if (pclk_i && !pclk_reg) begin
			word_o <= par_data_i;
			period_o <= cnt_reg;
			high_o <= hi_reg;
			cnt_reg <= 8'h01;
			hi_reg <= 8'h01;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
			hi_reg <= hi_reg + {7'h00, pclk_i};
		end
	end
endmodule

/* File: sim/tb.sv */
// self-checking bench for the receiver lock and deserializer block
`timescale 1ns/100ps
module tb;
	import hdsrx_pkg::*;
	localparam logic [19:0] PAT = 20'h0000b;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, analog_bit_i, digital_bit_i;
	logic integrator_sat_high_i, integrator_sat_low_i, quad_window_i, carrier_detect_i, level_low_i;
	logic mute_level_adjust_i, bypass_n_i, serial_drive_enable_n_i, analog_select_i;
	logic sweep_up_o, sweep_down_o, lock_o, serial_drive_out_o, serial_drive_oe_o;
	logic carrier_present_n_o, mute_o, pclk_o, irq_o;
	logic [7:0]        wb_adr_i;
	logic [3:0]        wb_sel_i;
	logic [31:0]       wb_dat_i, wb_dat_o, d;
	logic [WORD_W-1:0] par_data_o, word_o;
	logic [7:0]        period_o, high_o;
	int                n_errors, checks_done, idx;

	hdsrx_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .analog_bit_i(analog_bit_i),
		.digital_bit_i(digital_bit_i), .integrator_sat_high_i(integrator_sat_high_i),
		.integrator_sat_low_i(integrator_sat_low_i), .quad_window_i(quad_window_i),
		.carrier_detect_i(carrier_detect_i), .level_low_i(level_low_i),
		.mute_level_adjust_i(mute_level_adjust_i), .bypass_n_i(bypass_n_i),
		.serial_drive_enable_n_i(serial_drive_enable_n_i), .analog_select_i(analog_select_i),
		.sweep_up_o(sweep_up_o), .sweep_down_o(sweep_down_o), .lock_o(lock_o),
		.serial_drive_out_o(serial_drive_out_o), .serial_drive_oe_o(serial_drive_oe_o),
		.carrier_present_n_o(carrier_present_n_o), .mute_o(mute_o), .par_data_o(par_data_o),
		.pclk_o(pclk_o), .irq_o(irq_o));
	hdsrx_deform_model sink_u (.clk_i(clk_i), .rst_i(rst_i), .par_data_i(par_data_o), .pclk_i(pclk_o),
		.word_o(word_o), .period_o(period_o), .high_o(high_o));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// serial stream: selected input carries the pattern, the other its inverse
	always @(posedge clk_i) begin
		idx <= (idx == 19) ? 0 : idx + 1;
		digital_bit_i <= analog_select_i ? ~PAT[idx] : PAT[idx];
		analog_bit_i <= analog_select_i ? PAT[idx] : ~PAT[idx];
	end

	function automatic logic is_rot(input logic [19:0] w);
		for (int r = 0; r < 20; r++) begin
			if (w === ((PAT >> r) | (PAT << (20 - r)))) return 1'b1;
		end
		return 1'b0;
	endfunction
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t %s: seen %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= wd;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		d = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (n >= 20) begin
			n_errors++;
			$display("ERROR %0t bus answer missing", $time);
			end_sim();
		end
		@(posedge clk_i);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wait_lock(input logic v);
		int n;
		for (n = 0; n < 30000 && lock_o !== v; n++) @(posedge clk_i);
		if (n >= 30000) begin
			n_errors++;
			$display("ERROR %0t lock wait ran out", $time);
			end_sim();
		end
	endtask

	task automatic t_regs();
		wb_xfer(1'b0, OFS_CTRL, 32'h0); check(d, {30'h0, CTRL_RESET}, "ctrl reset");
		wb_xfer(1'b1, 8'h40, 32'hffff_ffff);
		wb_xfer(1'b0, 8'h40, 32'h0); check(d, 32'h0, "unmapped read");
		wb_xfer(1'b0, OFS_CTRL, 32'h0); check(d, {30'h0, CTRL_RESET}, "unmapped write");
		check(carrier_present_n_o, 1'b1, "carrier idle");
		$display("test regs done");
	endtask
	task automatic t_words();
		for (int s = 0; s < 2; s++) begin
			analog_select_i <= s[0];
			settle(65);
			check(is_rot(word_o), 1'b1, "word content");
			check(period_o, 8'd20, "word clock period");
			check(high_o, 8'd10, "word clock high");
			check(lock_o, 1'b0, "unlocked while running");
			for (int k = 0; k < 20; k++) begin
				@(posedge clk_i);
				d[k] = serial_drive_out_o;
			end
			check(is_rot(d[19:0]), 1'b1, "serial out stream");
		end
		analog_select_i <= 1'b0;
		$display("test words done");
	endtask
	task automatic t_lock();
		wb_xfer(1'b1, OFS_IRQ_CLR, 32'hf);
		integrator_sat_high_i <= 1'b1;
		settle(6);
		check({sweep_up_o, sweep_down_o}, 2'b01, "sweep down at top");
		integrator_sat_high_i <= 1'b0;
		integrator_sat_low_i <= 1'b1;
		settle(6);
		check({sweep_up_o, sweep_down_o}, 2'b10, "sweep up at bottom");
		integrator_sat_low_i <= 1'b0;
		wb_xfer(1'b0, OFS_IRQ_STAT, 32'h0); check(d[EV_REVERSE], 1'b1, "reverse event");
		quad_window_i <= 1'b1;
		wait_lock(1'b1);
		check({sweep_up_o, sweep_down_o}, 2'b00, "sweep stops at lock");
		wb_xfer(1'b0, OFS_STATUS, 32'h0); check(d[ST_PHASE], 1'b1, "phase lock");
		integrator_sat_high_i <= 1'b1;
		settle(6);
		check(lock_o, 1'b0, "no data drops lock");
		integrator_sat_high_i <= 1'b0;
		wait_lock(1'b1);
		bypass_n_i <= 1'b0;
		settle(65);
		check(lock_o, 1'b1, "lock kept in bypass");
		check(is_rot(word_o), 1'b1, "bypass words");
		quad_window_i <= 1'b0;
		wait_lock(1'b0);
		bypass_n_i <= 1'b1;
		$display("test lock done");
	endtask
	task automatic t_irq();
		wb_xfer(1'b1, OFS_IRQ_CLR, 32'hf);
		wb_xfer(1'b1, OFS_IRQ_EN, 32'h8);
		check(irq_o, 1'b0, "irq idle");
		carrier_detect_i <= 1'b1;
		settle(6);
		check(carrier_present_n_o, 1'b0, "carrier seen");
		check(irq_o, 1'b1, "irq raised");
		wb_xfer(1'b1, OFS_IRQ_EN, 32'h0); check(irq_o, 1'b0, "irq masked");
		wb_xfer(1'b0, OFS_IRQ_STAT, 32'h0); check(d[EV_CARRIER], 1'b1, "carrier event");
		wb_xfer(1'b1, OFS_IRQ_CLR, 32'h8);
		wb_xfer(1'b0, OFS_IRQ_STAT, 32'h0); check(d[EV_CARRIER], 1'b0, "event cleared");
		carrier_detect_i <= 1'b0;
		settle(6);
		check(carrier_present_n_o, 1'b1, "carrier gone");
		$display("test irq done");
	endtask
	task automatic t_mute();
		wb_xfer(1'b1, OFS_CTRL, 32'h3);
		level_low_i <= 1'b1;
		mute_level_adjust_i <= 1'b1;
		settle(65);
		check(mute_o, 1'b1, "muted");
		check(word_o, 20'h0, "muted word");
		bypass_n_i <= 1'b0;
		settle(65);
		check(mute_o, 1'b0, "no mute in bypass");
		check(is_rot(word_o), 1'b1, "bypass ignores mute");
		bypass_n_i <= 1'b1;
		mute_level_adjust_i <= 1'b0;
		settle(65);
		check(mute_o, 1'b0, "adjust open");
		check(is_rot(word_o), 1'b1, "words back");
		level_low_i <= 1'b0;
		serial_drive_enable_n_i <= 1'b1;
		settle(6);
		check(serial_drive_oe_o, 1'b0, "driver off");
		serial_drive_enable_n_i <= 1'b0;
		settle(6);
		check(serial_drive_oe_o, 1'b1, "driver on");
		$display("test mute done");
	endtask

	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, integrator_sat_high_i, integrator_sat_low_i} = 5'h00;
		{quad_window_i, carrier_detect_i, level_low_i, mute_level_adjust_i} = 4'h0;
		{serial_drive_enable_n_i, analog_select_i} = 2'h0;
		bypass_n_i = 1'b1;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		n_errors = 0;
		checks_done = 0;
		rst_i = 1'b1;
		settle(2);
		rst_i <= 1'b0;
		settle(1);
		t_regs();
		t_words();
		t_lock();
		t_irq();
		t_mute();
		end_sim();
	end
endmodule
